/* File: rtl/gain_pkg.sv */
package gain_pkg;

   // Control cycle 100 us
   localparam int CLK_PERIOD_NS  = 50;
   localparam int CTRL_PERIOD_NS = 100000;
   localparam int CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [10:0] CTRL_CNT_MAX = 11'(CTRL_CYCLES - 1);

   // Units: filter 0.01 ms, switching 1 ms
   localparam int FILTER_UNIT_NS = 10000;
   localparam int SWITCH_UNIT_NS = 1000000;
   localparam logic [15:0] TS_UNITS       = 16'(CTRL_PERIOD_NS / FILTER_UNIT_NS);
   localparam logic [19:0] TICKS_PER_UNIT = 20'(SWITCH_UNIT_NS / CTRL_PERIOD_NS);

   // Register byte offsets
   localparam logic [7:0] OFS_FB_FILTER  = 8'h00;
   localparam logic [7:0] OFS_AUTOTUNE   = 8'h04;
   localparam logic [7:0] OFS_COMP_RATIO = 8'h08;
   localparam logic [7:0] OFS_INERTIA    = 8'h0C;
   localparam logic [7:0] OFS_SWITCH_CFG = 8'h10;
   localparam logic [7:0] OFS_DELAY_12   = 8'h14;
   localparam logic [7:0] OFS_DELAY_21   = 8'h18;
   localparam logic [7:0] OFS_TIME_12    = 8'h1C;
   localparam logic [7:0] OFS_TIME_21    = 8'h20;
   localparam logic [7:0] OFS_STATUS     = 8'h24;
   localparam logic [1:0] GAIN_REGION    = 2'h1;

   // Values after reset
   localparam logic [15:0] RST_FB_FILTER  = 16'h0000;
   localparam logic [15:0] RST_AUTOTUNE   = 16'h0012;
   localparam logic [15:0] RST_INERTIA    = 16'h0000;
   localparam logic [15:0] RST_SWITCH_CFG = 16'h0000;
   localparam logic [15:0] RST_DELAY      = 16'h0000;
   localparam logic [15:0] RST_TIME       = 16'h0000;
   localparam logic [8:0]  RST_COMP_RATIO = 9'h064;
   localparam logic [8:0]  COMP_RATIO_MIN = 9'h001;
   localparam logic [8:0]  COMP_RATIO_MAX = 9'h1F4;
   localparam logic [23:0] COMP_PERCENT   = 24'h000064;
   // Per set: 40.0 Hz, 20.00 ms, 40.0/s, 1.00 ms
   localparam logic [15:0] RST_GAIN [4] = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064};

   // Digit codes
   localparam logic [3:0] MODE_MANUAL        = 4'h0;
   localparam logic [3:0] MODE_AUTO1         = 4'h1;
   localparam logic [3:0] COMP_ON_DIGIT      = 4'h0;
   localparam logic [3:0] AUTOTUNE_OFF_DIGIT = 4'h2;
   localparam logic [3:0] COND_DONE_ON       = 4'h0;
   localparam logic [3:0] COND_DONE_OFF      = 4'h1;
   localparam logic [3:0] COND_NEAR_ON       = 4'h2;
   localparam logic [3:0] COND_NEAR_OFF      = 4'h3;
   localparam logic [3:0] COND_REF_IDLE      = 4'h4;
   localparam logic [3:0] COND_PULSE_ON      = 4'h5;

   // Arithmetic job sequence per control cycle
   localparam logic [2:0] JOB_FILTER = 3'h0;
   localparam logic [2:0] JOB_COMP   = 3'h1;
   localparam logic [2:0] JOB_RAMP0  = 3'h2;
   localparam logic [2:0] JOB_LAST   = 3'h5;
   localparam int DIV_STEPS = 40;

   typedef enum logic [2:0] {
      AUTO_SET1   = 3'b000,
      AUTO_DLY12  = 3'b001,
      AUTO_RAMP12 = 3'b010,
      AUTO_SET2   = 3'b011,
      AUTO_DLY21  = 3'b100,
      AUTO_RAMP21 = 3'b101
   } auto_state_t;

   typedef struct packed {
      logic [15:0] speed_gain;
      logic [15:0] speed_itc;
      logic [15:0] pos_gain;
      logic [15:0] torque_tc;
   } gain_set_t;

   typedef struct packed {
      logic positioning_done;
      logic positioning_near;
      logic ref_filter_busy;
      logic ref_pulse;
   } pos_status_t;

endpackage

/* File: rtl/serial_div.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_div
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        start_in,
   input  wire logic [39:0] dividend_in,
   input  wire logic [23:0] divisor_in,
   output logic             done_out,
   output logic [39:0]      quotient_out
);

   logic [23:0] rem_q;
   logic [23:0] div_q;
   logic [5:0]  cnt_q;
   logic [24:0] shifted;
   logic [24:0] diff;
   logic        fits;

   // Restoring division, a bit per clock
   assign shifted = {rem_q, quotient_out[39]};
   assign diff    = shifted - {1'b0, div_q};
   assign fits    = shifted >= {1'b0, div_q};

   // Divisor of zero yields all ones; ramp jobs issue one whenever n_ticks is 0
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         rem_q        <= 24'h000000;
         div_q        <= 24'h000000;
         cnt_q        <= 6'h00;
         done_out     <= 1'b0;
         quotient_out <= 40'h0000000000;
      end
      else if (start_in)
      begin
         rem_q        <= 24'h000000;
         div_q        <= divisor_in;
         cnt_q        <= 6'(gain_pkg::DIV_STEPS);
         done_out     <= 1'b0;
         quotient_out <= dividend_in;
      end
      else
      begin
         done_out <= cnt_q == 6'h01;
         if (cnt_q != 6'h00)
         begin
            cnt_q        <= cnt_q - 6'h01;
            rem_q        <= fits ? diff[23:0] : shifted[23:0];
            quotient_out <= {quotient_out[38:0], fits};
         end
      end
   end

endmodule
`default_nettype wire

/* File: rtl/gain_switch_fb.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (R1) Measured speed passes a first-order low-pass filter.
// (R2) Filter constant 0.00..655.35 ms, 0.01 ms steps, reset 0 = unfiltered.
// (R3) Method digit one: 0 compensated feedback, 1 plain feedback.
// (R4) Code 0002 enables compensation and switches online autotuning off.
// (R5) Compensation ratio 1..500 %, reset 100 %, scales feedback.
// (R6) Host sets inertia ratio correctly before enabling compensation.
// (R7) Manual mode: select 00,01,10,11 picks gain set 1,2,3,4.
// (R8) Switch config digit zero 0 selects manual switching.
// (R9) A set switches all four gain values together.
// (R10) Auto: condition A moves set 1 to 2, condition B moves 2 to 1.
// (R11) A held condition waits the switching delay first.
// (R12) Auto switching ramps gains linearly over the switching time.
// (R13) Separate delay and time for the 1-to-2 and 2-to-1 transitions.
// (R14) Switch config digit zero 1 selects automatic pattern 1.
// (R15) Digits one and two pick conditions A and B from six status codes.
// (R16) Servo off or alarm in auto mode reverts to set 1; manual keeps select.
// (R17) Ramp updates every control cycle, ends exactly on target.
module gain_switch_fb
(
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   input  wire logic                  psel_in,
   input  wire logic                  penable_in,
   input  wire logic                  pwrite_in,
   input  wire logic [7:0]            paddr_in,
   input  wire logic [31:0]           pwdata_in,
   output logic [31:0]                prdata_out,
   output logic                       pready_out,
   output logic                       pslverr_out,
   input  wire logic signed [15:0]    speed_meas_in,
   input  wire gain_pkg::pos_status_t status_in,
   input  wire logic                  servo_on_in,
   input  wire logic                  alarm_in,
   input  wire logic [1:0]            gain_select_in,
   output gain_pkg::gain_set_t        gains_out,
   output logic signed [15:0]         speed_fb_out,
   output logic [1:0]                 active_set_out,
   output logic                       ramp_busy_out,
   output logic                       comp_en_out,
   output logic                       autotune_en_out
);

   logic [15:0]          fb_filter_q;
   logic [15:0]          autotune_q;
   logic [8:0]           comp_ratio_q;
   logic [15:0]          inertia_q;
   logic [15:0]          switch_cfg_q;
   logic [15:0]          delay12_q;
   logic [15:0]          delay21_q;
   logic [15:0]          time12_q;
   logic [15:0]          time21_q;
   logic [15:0]          gain_q [16];
   logic [15:0]          ramp_val_q [4];
   logic [10:0]          ctrl_cnt_q;
   logic                 tick_q;
   logic [19:0]          phase_cnt_q;
   logic [2:0]           job_q;
   logic                 div_start_q;
   logic                 job_neg_q;
   logic signed [15:0]   filt_q;
   logic signed [15:0]   comp_q;
   gain_pkg::auto_state_t auto_q;
   gain_pkg::auto_state_t auto_d;

   // Bus decode, one wait state
   logic        access;
   logic        wr_en;
   logic        in_gain;
   logic        mapped;
   logic [15:0] wr16;
   logic [8:0]  ratio_wr;
   logic [31:0] rd_data;
   logic [31:0] status_word;

   assign access   = psel_in && penable_in;
   assign wr_en    = access && pwrite_in && pready_out && !pslverr_out;
   assign in_gain  = paddr_in[7:6] == gain_pkg::GAIN_REGION && paddr_in[1:0] == 2'h0;
   assign wr16     = pwdata_in[15:0];
   assign mapped   = in_gain || (paddr_in <= gain_pkg::OFS_STATUS && paddr_in[1:0] == 2'h0);
   // Out-of-range ratio writes clamp rather than fault
   assign ratio_wr = (wr16 > 16'(gain_pkg::COMP_RATIO_MAX)) ? gain_pkg::COMP_RATIO_MAX :
                     (wr16 == 16'h0000) ? gain_pkg::COMP_RATIO_MIN : wr16[8:0]; // R5
   assign status_word = {24'h000000, autotune_en_out, comp_en_out, ramp_busy_out, auto_q, active_set_out};
   assign rd_data  = in_gain ? {16'h0000, gain_q[paddr_in[5:2]]} :
                     (paddr_in == gain_pkg::OFS_FB_FILTER)  ? {16'h0000, fb_filter_q} :
                     (paddr_in == gain_pkg::OFS_AUTOTUNE)   ? {16'h0000, autotune_q} :
                     (paddr_in == gain_pkg::OFS_COMP_RATIO) ? {23'h000000, comp_ratio_q} :
                     (paddr_in == gain_pkg::OFS_INERTIA)    ? {16'h0000, inertia_q} :
                     (paddr_in == gain_pkg::OFS_SWITCH_CFG) ? {16'h0000, switch_cfg_q} :
                     (paddr_in == gain_pkg::OFS_DELAY_12)   ? {16'h0000, delay12_q} :
                     (paddr_in == gain_pkg::OFS_DELAY_21)   ? {16'h0000, delay21_q} :
                     (paddr_in == gain_pkg::OFS_TIME_12)    ? {16'h0000, time12_q} :
                     (paddr_in == gain_pkg::OFS_TIME_21)    ? {16'h0000, time21_q} :
                     (paddr_in == gain_pkg::OFS_STATUS)     ? status_word : 32'h00000000;

   // Bus handshake
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h00000000;
      end
      else
      begin
         pready_out  <= access && !pready_out;
         pslverr_out <= access && !pready_out && !mapped;
         prdata_out  <= (access && !pready_out && !pwrite_in) ? rd_data : 32'h00000000;
      end
   end

   // Scalar registers, effective at once
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         fb_filter_q  <= gain_pkg::RST_FB_FILTER;
         autotune_q   <= gain_pkg::RST_AUTOTUNE;
         comp_ratio_q <= gain_pkg::RST_COMP_RATIO;
         inertia_q    <= gain_pkg::RST_INERTIA;
         switch_cfg_q <= gain_pkg::RST_SWITCH_CFG;
         delay12_q    <= gain_pkg::RST_DELAY;
         delay21_q    <= gain_pkg::RST_DELAY;
         time12_q     <= gain_pkg::RST_TIME;
         time21_q     <= gain_pkg::RST_TIME;
      end
      else if (wr_en)
      begin
         if (paddr_in == gain_pkg::OFS_FB_FILTER)  fb_filter_q  <= wr16; // R2
         if (paddr_in == gain_pkg::OFS_AUTOTUNE)   autotune_q   <= wr16;
         if (paddr_in == gain_pkg::OFS_COMP_RATIO) comp_ratio_q <= ratio_wr;
         if (paddr_in == gain_pkg::OFS_INERTIA)    inertia_q    <= wr16;
         if (paddr_in == gain_pkg::OFS_SWITCH_CFG) switch_cfg_q <= wr16;
         if (paddr_in == gain_pkg::OFS_DELAY_12)   delay12_q    <= wr16; // R13
         if (paddr_in == gain_pkg::OFS_DELAY_21)   delay21_q    <= wr16;
         if (paddr_in == gain_pkg::OFS_TIME_12)    time12_q     <= wr16;
         if (paddr_in == gain_pkg::OFS_TIME_21)    time21_q     <= wr16;
      end
   end

   // Gain entries: set * 4 + parameter
   gain_pkg::gain_set_t set_v [4];
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_gain
         always_ff @(posedge mclk_in)
         begin
            if (rst_in)
               gain_q[gi] <= gain_pkg::RST_GAIN[gi % 4];
            else if (wr_en && in_gain && paddr_in[5:2] == 4'(gi))
               gain_q[gi] <= wr16;
         end
      end
      for (gi = 0; gi < 4; gi++)
      begin : g_set
         assign set_v[gi] = {gain_q[gi*4], gain_q[gi*4+1], gain_q[gi*4+2], gain_q[gi*4+3]}; // R9
      end
   endgenerate

   // Control cycle timebase
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         ctrl_cnt_q <= 11'h000;
         tick_q     <= 1'b0;
      end
      else
      begin
         ctrl_cnt_q <= (ctrl_cnt_q == gain_pkg::CTRL_CNT_MAX) ? 11'h000 : ctrl_cnt_q + 11'h001;
         tick_q     <= ctrl_cnt_q == gain_pkg::CTRL_CNT_MAX;
      end
   end

   // Switching conditions
   function automatic logic cond_eval(input logic [3:0] code, input gain_pkg::pos_status_t st);
      logic r;
      r = 1'b0;
      case (code)
         gain_pkg::COND_DONE_ON:  r = st.positioning_done;
         gain_pkg::COND_DONE_OFF: r = !st.positioning_done;
         gain_pkg::COND_NEAR_ON:  r = st.positioning_near;
         gain_pkg::COND_NEAR_OFF: r = !st.positioning_near;
         gain_pkg::COND_REF_IDLE: r = !st.ref_filter_busy && !st.ref_pulse;
         gain_pkg::COND_PULSE_ON: r = st.ref_pulse;
         default:                 r = 1'b0;
      endcase
      return r;
   endfunction

   logic        auto_en;
   logic        halt;
   logic        cond_a;
   logic        cond_b;
   logic        up_dir;
   logic        ramping;
   logic [19:0] delay_ticks;
   logic [19:0] n_ticks;
   logic [1:0]  from_idx;
   logic [1:0]  to_idx;

   assign auto_en  = switch_cfg_q[3:0] == gain_pkg::MODE_AUTO1; // R8 R14
   assign halt     = !servo_on_in || alarm_in;
   assign cond_a   = cond_eval(switch_cfg_q[7:4], status_in); // R15
   assign cond_b   = cond_eval(switch_cfg_q[11:8], status_in);
   assign up_dir   = auto_q == gain_pkg::AUTO_DLY12 || auto_q == gain_pkg::AUTO_RAMP12;
   assign ramping  = auto_q == gain_pkg::AUTO_RAMP12 || auto_q == gain_pkg::AUTO_RAMP21;
   assign from_idx = up_dir ? 2'h0 : 2'h1;
   assign to_idx   = up_dir ? 2'h1 : 2'h0;
   // 1 ms units counted in control ticks
   assign delay_ticks = 20'({4'h0, up_dir ? delay12_q : delay21_q} * gain_pkg::TICKS_PER_UNIT); // R13
   assign n_ticks     = 20'({4'h0, up_dir ? time12_q : time21_q} * gain_pkg::TICKS_PER_UNIT);

   // Auto switching; illegal codes go to set 1
   always_comb
   begin
      auto_d = auto_q;
      if (!auto_en || halt)
         auto_d = gain_pkg::AUTO_SET1; // R16
      else
         unique case (auto_q)
            gain_pkg::AUTO_SET1:
               if (cond_a) auto_d = gain_pkg::AUTO_DLY12; // R10
            gain_pkg::AUTO_DLY12:
               if (!cond_a) auto_d = gain_pkg::AUTO_SET1; // R11
               else if (tick_q && phase_cnt_q >= delay_ticks)
                  auto_d = (n_ticks == 20'h00000) ? gain_pkg::AUTO_SET2 : gain_pkg::AUTO_RAMP12;
            gain_pkg::AUTO_RAMP12:
               if (tick_q && phase_cnt_q >= n_ticks) auto_d = gain_pkg::AUTO_SET2; // R12
            gain_pkg::AUTO_SET2:
               if (cond_b) auto_d = gain_pkg::AUTO_DLY21; // R10
            gain_pkg::AUTO_DLY21:
               if (!cond_b) auto_d = gain_pkg::AUTO_SET2; // R11
               else if (tick_q && phase_cnt_q >= delay_ticks)
                  auto_d = (n_ticks == 20'h00000) ? gain_pkg::AUTO_SET1 : gain_pkg::AUTO_RAMP21;
            gain_pkg::AUTO_RAMP21:
               if (tick_q && phase_cnt_q >= n_ticks) auto_d = gain_pkg::AUTO_SET1; // R12
            default:
               auto_d = gain_pkg::AUTO_SET1;
         endcase
   end

   // Phase counter doubles as delay count and ramp step
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         auto_q      <= gain_pkg::AUTO_SET1;
         phase_cnt_q <= 20'h00000;
      end
      else
      begin
         auto_q      <= auto_d;
         phase_cnt_q <= (auto_d != auto_q) ? 20'h00000 : phase_cnt_q + 20'(tick_q);
      end
   end

   // Shared divider jobs
   logic [1:0]          job_p;
   logic signed [16:0]  delta;
   logic signed [39:0]  y_x;
   logic signed [39:0]  filt_num;
   logic signed [39:0]  comp_num;
   logic signed [39:0]  ramp_num;
   logic signed [39:0]  job_num;
   logic [23:0]         job_den;
   logic                div_done;
   logic [39:0]         div_quo;
   logic signed [39:0]  res;
   logic signed [15:0]  res_sat;

   assign job_p    = 2'(job_q - gain_pkg::JOB_RAMP0);
   assign delta    = $signed({1'b0, gain_q[{to_idx, job_p}]}) - $signed({1'b0, gain_q[{from_idx, job_p}]});
   assign y_x      = 40'(filt_q);
   // y = (tau*y + Ts*x) / (tau + Ts); tau of zero passes speed straight through
   assign filt_num = $signed({24'h000000, fb_filter_q}) * y_x
                   + $signed({24'h000000, gain_pkg::TS_UNITS}) * 40'(speed_meas_in); // R1
   assign comp_num = y_x * $signed({31'h00000000, comp_ratio_q}); // R5
   assign ramp_num = 40'(delta) * $signed({20'h00000, phase_cnt_q}); // R12
   assign job_num  = (job_q == gain_pkg::JOB_FILTER) ? filt_num :
                     (job_q == gain_pkg::JOB_COMP) ? comp_num : ramp_num;
   assign job_den  = (job_q == gain_pkg::JOB_FILTER) ? {8'h00, fb_filter_q} + {8'h00, gain_pkg::TS_UNITS} :
                     (job_q == gain_pkg::JOB_COMP) ? gain_pkg::COMP_PERCENT : {4'h0, n_ticks};
   assign res      = job_neg_q ? -$signed(div_quo) : $signed(div_quo);
   // Saturate to the 16-bit speed range; 500 % can overflow it
   assign res_sat  = (res > 40'sd32767) ? 16'sh7FFF : (res < -40'sd32768) ? -16'sh8000 : 16'(res);

   serial_div u_div
   (
      .mclk_in      (mclk_in),
      .rst_in       (rst_in),
      .start_in     (div_start_q),
      .dividend_in  (job_num[39] ? 40'(-job_num) : 40'(job_num)),
      .divisor_in   (job_den),
      .done_out     (div_done),
      .quotient_out (div_quo)
   );

   // Job sequencer, restarted per tick
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         job_q       <= gain_pkg::JOB_FILTER;
         div_start_q <= 1'b0;
         job_neg_q   <= 1'b0;
         filt_q      <= 16'sh0000;
         comp_q      <= 16'sh0000;
      end
      else
      begin
         div_start_q <= tick_q || (div_done && job_q != gain_pkg::JOB_LAST);
         if (tick_q)
            job_q <= gain_pkg::JOB_FILTER;
         else if (div_done && job_q != gain_pkg::JOB_LAST)
            job_q <= job_q + 3'h1;
         if (div_start_q)
            job_neg_q <= job_num[39];
         if (div_done && job_q == gain_pkg::JOB_FILTER)
            filt_q <= res_sat; // R1
         if (div_done && job_q == gain_pkg::JOB_COMP)
            comp_q <= res_sat;
      end
   end

   // Ramp values from start set
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_ramp
         always_ff @(posedge mclk_in)
         begin
            if (rst_in)
               ramp_val_q[gi] <= gain_pkg::RST_GAIN[gi];
            else if (!ramping || auto_d != auto_q)
               ramp_val_q[gi] <= gain_q[{from_idx, 2'(gi)}];
            else if (div_done && job_q >= gain_pkg::JOB_RAMP0 && job_p == 2'(gi))
               ramp_val_q[gi] <= gain_q[{from_idx, 2'(gi)}] + res[15:0]; // R17
         end
      end
   endgenerate

   // Registered outputs
   gain_pkg::gain_set_t gains_d;
   logic [1:0]          set_d;
   assign set_d   = !auto_en ? gain_select_in : // R7 R16
                    (auto_q == gain_pkg::AUTO_SET1 || auto_q == gain_pkg::AUTO_DLY12 ||
                     auto_q == gain_pkg::AUTO_RAMP21) ? 2'h0 : 2'h1;
   // Stable states take set values directly, so a ramp lands exactly
   assign gains_d = (auto_en && ramping) ? {ramp_val_q[0], ramp_val_q[1], ramp_val_q[2], ramp_val_q[3]} :
                    !auto_en ? set_v[gain_select_in] : // R7
                    set_v[(auto_q == gain_pkg::AUTO_SET1 || auto_q == gain_pkg::AUTO_DLY12) ? 2'h0 : 2'h1]; // R17

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         gains_out       <= {gain_pkg::RST_GAIN[0], gain_pkg::RST_GAIN[1], gain_pkg::RST_GAIN[2], gain_pkg::RST_GAIN[3]};
         speed_fb_out    <= 16'sh0000;
         active_set_out  <= 2'h0;
         ramp_busy_out   <= 1'b0;
         comp_en_out     <= 1'b0;
         autotune_en_out <= 1'b0;
      end
      else
      begin
         gains_out       <= gains_d; // R9
         comp_en_out     <= autotune_q[7:4] == gain_pkg::COMP_ON_DIGIT; // R3
         speed_fb_out    <= comp_en_out ? comp_q : filt_q; // R3 R5
         active_set_out  <= set_d;
         ramp_busy_out   <= auto_en && ramping;
         autotune_en_out <= autotune_q[3:0] != gain_pkg::AUTOTUNE_OFF_DIGIT; // R4
      end
   end

endmodule
`default_nettype wire

/* File: dv/gain_switch_fb_props.sv */
`timescale 1ns/100ps
`default_nettype none
module gain_switch_fb_props
(
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        servo_on_in,
   input wire logic        alarm_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic [1:0]  active_set_out,
   input wire logic        ramp_busy_out,
   input wire logic        comp_en_out,
   input wire logic        autotune_en_out
);
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   // Completed transfer
   wire xfer_done = psel_in && penable_in && pready_out;
   // Bus phases
   sequence setup_s;
      psel_in && !penable_in;
   endsequence
   sequence access_s;
      psel_in && penable_in;
   endsequence
   one_wait_a: assert property (setup_s ##1 access_s |-> !pready_out ##1 pready_out)
      else $error("wait states");
   ready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready held");
   err_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("stray read data");
   halt_ramp_a: assert property ((!servo_on_in || alarm_in) |-> ##2 !ramp_busy_out)
      else $error("ramp survives halt");
   ramp_set_a: assert property (ramp_busy_out |-> active_set_out[1] == 1'b0)
      else $error("ramp set");
   comp_move_a: assert property ($changed(comp_en_out) |-> $past(xfer_done) || $past(xfer_done, 2))
      else $error("comp flag moved");
   tune_move_a: assert property ($changed(autotune_en_out) |-> $past(xfer_done) || $past(xfer_done, 2))
      else $error("tune flag moved");
endmodule
bind gain_switch_fb gain_switch_fb_props chk (.mclk_in, .rst_in, .psel_in, .penable_in, .servo_on_in,
   .alarm_in, .prdata_out, .pready_out, .pslverr_out, .active_set_out, .ramp_busy_out, .comp_en_out,
   .autotune_en_out);
`default_nettype wire

/* File: dv/host_cmd_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_cmd_model
(
   input  wire logic           mclk_in,
   input  wire logic [1:0]     sel_req_in,
   input  wire logic           done_req_in,
   output logic [1:0]          gain_select_out,
   output gain_pkg::pos_status_t status_out
);
   // Option field and status, latched as levels
   always_ff @(posedge mclk_in)
   begin
      gain_select_out <= sel_req_in;
      status_out <= {done_req_in, 3'h0};
   end
endmodule
`default_nettype wire

/* File: dv/gain_switch_fb_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module gain_switch_fb_tb;
   logic mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic servo_on = 1'b1, alarm = 1'b0, done_req = 1'b0, ramp_busy, comp_en, tune_en;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, pv;
   logic [1:0] sel_req = 2'h0, gsel, act;
   logic signed [15:0] meas = 16'h0000, fb, old;
   gain_pkg::pos_status_t status;
   gain_pkg::gain_set_t gains;
   logic [15:0] gv [16];
   int fails = 0, checks_done = 0, cyc = 0, seed = 32'hB6F6, i;
   always #25 mclk_in = ~mclk_in;
   host_cmd_model host (.mclk_in(mclk_in), .sel_req_in(sel_req), .done_req_in(done_req),
      .gain_select_out(gsel), .status_out(status));
   gain_switch_fb dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .speed_meas_in(meas), .status_in(status), .servo_on_in(servo_on),
      .alarm_in(alarm), .gain_select_in(gsel), .gains_out(gains), .speed_fb_out(fb),
      .active_set_out(act), .ramp_busy_out(ramp_busy), .comp_en_out(comp_en), .autotune_en_out(tune_en));
   task stop_test;
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         fails++;
         stop_test;
      end
   end
   task chk(input logic [79:0] got, exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk_in);
      penable <= 1'b1;
      do
         @(posedge mclk_in);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task wait_ramp(input logic want, input int lim);
      for (int n = 0; n < lim && ramp_busy !== want; n++)
         @(posedge mclk_in);
   endtask
   // Wait for the next output update
   task wait_fb;
      old = fb;
      for (int n = 0; n < 2100 && fb === old; n++)
         @(posedge mclk_in);
      repeat (100) @(posedge mclk_in);
   endtask
   function logic [15:0] filt(int y, x, tau);
      return 16'((tau * y + 10 * x) / (tau + 10));
   endfunction
   function gain_pkg::gain_set_t set_of(int k);
      return {gv[4 * k], gv[4 * k + 1], gv[4 * k + 2], gv[4 * k + 3]};
   endfunction
   initial
   begin
      for (i = 0; i < 16; i++)
         gv[i] = gain_pkg::RST_GAIN[i % 4];
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      chk(gains, set_of(0), "reset gains");
      apb(0, gain_pkg::OFS_AUTOTUNE, 32'h0);
      chk(rd, 32'h12, "method reset");
      apb(0, 8'hFC, 32'h0);
      chk({err, rd}, 33'h100000000, "unmapped");
      // Ratio clamp, filter readback
      apb(1, gain_pkg::OFS_COMP_RATIO, 32'h0);
      apb(0, gain_pkg::OFS_COMP_RATIO, 32'h0);
      chk(rd, 32'h1, "ratio low");
      apb(1, gain_pkg::OFS_COMP_RATIO, 32'h258);
      apb(0, gain_pkg::OFS_COMP_RATIO, 32'h0);
      chk(rd, 32'h1F4, "ratio high");
      pv = $random(seed);
      apb(1, gain_pkg::OFS_FB_FILTER, pv);
      apb(0, gain_pkg::OFS_FB_FILTER, 32'h0);
      chk(rd, {16'h0, pv[15:0]}, "filter tc");
      for (i = 0; i < 16; i++)
      begin
         gv[i] = 16'($random(seed));
         apb(1, 8'h40 + 8'(4 * i), {16'h0, gv[i]});
      end
      // Manual select under halts
      for (i = 0; i < 8; i++)
      begin
         {alarm, sel_req} <= 3'(i);
         servo_on <= ~i[2];
         repeat (4) @(posedge mclk_in);
         chk({act, gains}, {i[1:0], set_of(i % 4)}, "manual set");
      end
      {alarm, servo_on} <= 2'b01;
      apb(1, gain_pkg::OFS_FB_FILTER, 32'h0);
      meas <= 16'h03E8;
      wait_fb;
      chk(fb, 16'h03E8, "unfiltered");
      meas <= 16'hFED3;
      apb(1, gain_pkg::OFS_FB_FILTER, 32'hA);
      wait_fb;
      chk(fb, filt(1000, -301, 10), "filtered");
      apb(1, gain_pkg::OFS_FB_FILTER, 32'h0);
      apb(1, gain_pkg::OFS_COMP_RATIO, 32'h32);
      apb(1, gain_pkg::OFS_INERTIA, 32'h8);
      apb(1, gain_pkg::OFS_AUTOTUNE, 32'h2);
      wait_fb;
      wait_fb;
      chk({comp_en, tune_en, fb}, {2'b10, 16'(-301 * 50 / 100)}, "compensated");
      apb(1, gain_pkg::OFS_AUTOTUNE, 32'h10);
      repeat (2) @(posedge mclk_in);
      chk({comp_en, tune_en}, 2'b01, "plain feedback");
      // Auto: 1 ms delay, 1 ms ramp
      apb(1, gain_pkg::OFS_DELAY_12, 32'h1);
      apb(1, gain_pkg::OFS_TIME_12, 32'h1);
      apb(1, gain_pkg::OFS_SWITCH_CFG, 32'h0101);
      done_req <= 1'b1;
      repeat (17000) @(posedge mclk_in);
      chk(ramp_busy, 1'b0, "delay hold");
      wait_ramp(1, 6000);
      chk({ramp_busy, act}, 3'b101, "ramp start");
      wait_ramp(0, 24000);
      chk({act, gains}, {2'h1, set_of(1)}, "ramp end");
      done_req <= 1'b0;
      repeat (4100) @(posedge mclk_in);
      chk({ramp_busy, act, gains}, {3'b000, set_of(0)}, "step back");
      apb(1, gain_pkg::OFS_DELAY_12, 32'h0);
      done_req <= 1'b1;
      wait_ramp(1, 4100);
      alarm <= 1'b1;
      repeat (3) @(posedge mclk_in);
      chk({ramp_busy, act, gains}, {3'b000, set_of(0)}, "alarm revert");
      stop_test;
   end
endmodule
`default_nettype wire
